// ==== hw/deser_parallel_output_status.sv ====
// Parallel pixel output, audio pins, status pins and register slave.
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`include "deser_out_defines.svh"
`default_nettype none
module deser_parallel_output_status
   import deser_out_pkg::*;
#(
   parameter int DATA_W = 29,
   parameter int CNT_W = 16,
   parameter int PATTERN_TEST_W = 8
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic link_clk,
   input wire logic [DATA_W-1:0] link_word,
   input wire logic [DATA_W-1:0] key_word,
   input wire logic key_sd,
   input wire logic decode_err_tgl,
   input wire logic pattern_test_err_tgl,
   input wire logic plls_locked,
   input wire logic word_aligned,
   input wire logic aud_sck,
   input wire logic aud_ws,
   input wire logic aud_sd,
   input wire logic aud_mclk,
   input wire logic power_down_n,
   input wire logic bus_width_sel,
   input wire logic edge_sel,
   input wire logic out_enable_n,
   input wire logic spread_strap,
   input wire logic rate_range_strap,
   output logic pixel_clk_out,
   output logic [DATA_W-1:0] pixel_data,
   output logic pixel_oe,
   output logic i2s_sck_out,
   output logic i2s_ws_out,
   output logic i2s_sd_out,
   output logic audio_oe,
   output logic video_err_out,
   output logic video_err_oe,
   output logic lock_out,
   output logic lock_oe,
   output logic spread_en,
   output logic low_rate_band
);
   // Sixteen single pins ride along with the two data words.
   localparam int SYNC_W = 2 * DATA_W + 16;
   logic [1:0] rst_sync;
   logic rst_n;
   logic [SYNC_W-1:0] sync_a, sync_b;
   logic [DATA_W-1:0] word_s, key_s;
   logic lclk_s, pd_s, bws_s, es_s, oen_s, spread_s, rate_s, locked_s;
   logic aligned_s, dec_s, pattern_test_s, sck_s, ws_s, sd_s, mclk_s, ksd_s;
   logic lclk_reg, lclk_next, pd_reg, pd_next;
   logic dec_reg, dec_next, pattern_test_reg, pattern_test_next;
   logic [CNT_W-1:0] dec_cnt_reg, dec_cnt_next;
   logic [PATTERN_TEST_W-1:0] pattern_test_cnt_reg, pattern_test_cnt_next;
   logic [`CTRL_W-1:0] ctrl_reg, ctrl_next;
   logic [15:0] thresh_reg, thresh_next;
   logic spread_reg, spread_next, rate_reg, rate_next;
   logic [DATA_W-1:0] data_reg, data_next;
   logic pclk_reg, pclk_next, poe_reg, poe_next;
   logic sck_reg, sck_next, ws_reg, ws_next, sdo_reg, sdo_next;
   logic err_oe_reg, err_oe_next, lock_oe_reg, lock_oe_next;
   bus_state_t wst_reg, wst_next, rst_st_reg, rst_st_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic upd, pd_rise, dec_ev, pattern_test_ev, cnt_clr, err_act, pattern_test;
   logic [DATA_W-1:0] word_mux;

   // Reset is released through two flops so all state leaves reset together.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // Every pin outside the register bus, clk_en and resetn, and the recovered clock, cross on two flops; only sync_b is read.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= '0;
         sync_b <= '0;
      end else if (clk_en) begin
         sync_a <= {link_clk, power_down_n, bus_width_sel, edge_sel,
                    out_enable_n, spread_strap, rate_range_strap, plls_locked,
                    word_aligned, decode_err_tgl, pattern_test_err_tgl, aud_sck,
                    aud_ws, aud_sd, aud_mclk, key_sd, link_word, key_word};
         sync_b <= sync_a;
      end
   end
   assign {lclk_s, pd_s, bws_s, es_s, oen_s, spread_s, rate_s, locked_s,
           aligned_s, dec_s, pattern_test_s, sck_s, ws_s, sd_s, mclk_s, ksd_s,
           word_s, key_s} = sync_b;

   assign pattern_test = ctrl_reg[`CTRL_PATTERN_TEST];
   // Edges of the sampled link clock; the pixel clock is this copy delayed.
   assign upd = es_s ? (lclk_reg & ~lclk_s) : (~lclk_reg & lclk_s);
   assign pd_rise = pd_s & ~pd_reg;
   // Error events arrive as toggles so none is lost in the crossing.
   assign dec_ev = (dec_s ^ dec_reg) & ~pattern_test;
   assign pattern_test_ev = (pattern_test_s ^ pattern_test_reg) & pattern_test;
   assign cnt_clr = (wst_reg == BUS_TAKE) && (s_axi_awaddr == `ADDR_ERRCNT);
   assign err_act = pd_s & ((dec_cnt_reg > CNT_W'(thresh_reg))
                   | (pattern_test & (pattern_test_cnt_reg != '0)));

   always_comb begin
      word_mux = word_s;
      if (ctrl_reg[`CTRL_ENCRYPT_EN]) begin
         // Sync bits and bits 28, 27, 20 bypass the cipher.
         word_mux = word_s ^ (key_s & `DECRYPT_MASK);
      end
      if (ctrl_reg[`CTRL_MCLK_SEL]) begin
         word_mux[28] = mclk_s;
      end
      if (!bws_s) begin
         word_mux = word_mux & `NARROW_MASK;
      end
   end

   always_comb begin
      lclk_next = lclk_s;
      pd_next = pd_s;
      dec_next = dec_s;
      pattern_test_next = pattern_test_s;
      pclk_next = lclk_s;
      poe_next = ~oen_s;
      data_next = data_reg;
      sck_next = sck_reg;
      ws_next = ws_reg;
      sdo_next = sdo_reg;
      if (upd) begin
         // Data change on the chosen edge and hold a full pixel period.
         data_next = word_mux;
         if (ctrl_reg[`CTRL_AUDIO_EN]) begin
            sck_next = sck_s;
            ws_next = ws_s;
            sdo_next = sd_s;
         end else begin
            sck_next = 1'b0;
            ws_next = 1'b0;
            sdo_next = ctrl_reg[`CTRL_SD_VALUE] ^
                       (ctrl_reg[`CTRL_ENCRYPT_EN] & ksd_s);
         end
      end
      // A new event in the clearing cycle still counts.
      dec_cnt_next = cnt_clr ? '0 : dec_cnt_reg;
      if (dec_ev && dec_cnt_next != '1) begin
         dec_cnt_next = dec_cnt_next + 1'b1;
      end
      pattern_test_cnt_next = (cnt_clr || !pattern_test) ? '0 : pattern_test_cnt_reg;
      if (pattern_test_ev && pattern_test_cnt_next != '1) begin
         pattern_test_cnt_next = pattern_test_cnt_next + 1'b1;
      end
      if (!pd_s) begin
         dec_cnt_next = '0;
         pattern_test_cnt_next = '0;
      end
      err_oe_next = err_act;
      lock_oe_next = pd_s & ~(locked_s & aligned_s
                     & ~ctrl_reg[`CTRL_CFG_LINK]);
      spread_next = spread_reg;
      rate_next = rate_reg;
      // Straps are taken only at wake, so a wandering pin changes nothing.
      if (pd_rise) begin
         spread_next = spread_s;
         rate_next = rate_s;
      end
   end

   always_comb begin
      wst_next = wst_reg;
      bresp_next = bresp_reg;
      ctrl_next = ctrl_reg;
      thresh_next = thresh_reg;
      unique case (wst_reg)
         BUS_IDLE: begin
            if (s_axi_awvalid && s_axi_wvalid) begin
               wst_next = BUS_TAKE;
            end
         end
         BUS_TAKE: begin
            wst_next = BUS_RESP;
            bresp_next = `RESP_OKAY;
            if (s_axi_awaddr == `ADDR_CTRL) begin
               if (s_axi_wstrb[0]) begin
                  ctrl_next = s_axi_wdata[`CTRL_W-1:0];
               end
            end else if (s_axi_awaddr == `ADDR_THRESH) begin
               if (s_axi_wstrb[0]) begin
                  thresh_next[7:0] = s_axi_wdata[7:0];
               end
               if (s_axi_wstrb[1]) begin
                  thresh_next[15:8] = s_axi_wdata[15:8];
               end
            end else if (s_axi_awaddr != `ADDR_ERRCNT &&
                         s_axi_awaddr != `ADDR_STATUS) begin
               bresp_next = `RESP_SLVERR;
            end
         end
         BUS_RESP: begin
            if (s_axi_bready) begin
               wst_next = BUS_IDLE;
            end
         end
         default: wst_next = BUS_IDLE;
      endcase
   end

   always_comb begin
      rst_st_next = rst_st_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      unique case (rst_st_reg)
         BUS_IDLE: begin
            if (s_axi_arvalid) begin
               rst_st_next = BUS_TAKE;
            end
         end
         BUS_TAKE: begin
            rst_st_next = BUS_RESP;
            rresp_next = `RESP_OKAY;
            rdata_next = 32'h0000_0000;
            if (s_axi_araddr == `ADDR_CTRL) begin
               rdata_next[`CTRL_W-1:0] = ctrl_reg;
            end else if (s_axi_araddr == `ADDR_THRESH) begin
               rdata_next[15:0] = thresh_reg;
            end else if (s_axi_araddr == `ADDR_STATUS) begin
               rdata_next[5:0] = {pd_s, bws_s, rate_reg, spread_reg,
                                  err_oe_reg, pd_s & ~lock_oe_reg};
            end else if (s_axi_araddr == `ADDR_ERRCNT) begin
               rdata_next[CNT_W-1:0] = dec_cnt_reg;
               rdata_next[16 +: PATTERN_TEST_W] = pattern_test_cnt_reg;
            end else begin
               rresp_next = `RESP_SLVERR;
            end
         end
         BUS_RESP: begin
            if (s_axi_rready) begin
               rst_st_next = BUS_IDLE;
            end
         end
         default: rst_st_next = BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lclk_reg <= 1'b0;
         pd_reg <= 1'b0;
         dec_reg <= 1'b0;
         pattern_test_reg <= 1'b0;
         pclk_reg <= 1'b0;
         poe_reg <= 1'b0;
         data_reg <= '0;
         sck_reg <= 1'b0;
         ws_reg <= 1'b0;
         sdo_reg <= 1'b0;
         dec_cnt_reg <= '0;
         pattern_test_cnt_reg <= '0;
         err_oe_reg <= 1'b0;
         lock_oe_reg <= 1'b0;
         spread_reg <= 1'b0;
         rate_reg <= 1'b0;
         ctrl_reg <= `CTRL_RST;
         thresh_reg <= `THRESH_RST;
         wst_reg <= BUS_IDLE;
         rst_st_reg <= BUS_IDLE;
         bresp_reg <= `RESP_OKAY;
         rresp_reg <= `RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end else if (clk_en) begin
         lclk_reg <= lclk_next;
         pd_reg <= pd_next;
         dec_reg <= dec_next;
         pattern_test_reg <= pattern_test_next;
         pclk_reg <= pclk_next;
         poe_reg <= poe_next;
         data_reg <= data_next;
         sck_reg <= sck_next;
         ws_reg <= ws_next;
         sdo_reg <= sdo_next;
         dec_cnt_reg <= dec_cnt_next;
         pattern_test_cnt_reg <= pattern_test_cnt_next;
         err_oe_reg <= err_oe_next;
         lock_oe_reg <= lock_oe_next;
         spread_reg <= spread_next;
         rate_reg <= rate_next;
         ctrl_reg <= ctrl_next;
         thresh_reg <= thresh_next;
         wst_reg <= wst_next;
         rst_st_reg <= rst_st_next;
         bresp_reg <= bresp_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
      end
   end

   assign s_axi_awready = (wst_reg == BUS_TAKE);
   assign s_axi_wready = (wst_reg == BUS_TAKE);
   assign s_axi_bvalid = (wst_reg == BUS_RESP);
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = (rst_st_reg == BUS_TAKE);
   assign s_axi_rvalid = (rst_st_reg == BUS_RESP);
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign pixel_clk_out = pclk_reg;
   assign pixel_data = data_reg;
   assign pixel_oe = poe_reg;
   assign audio_oe = poe_reg;
   assign i2s_sck_out = sck_reg;
   assign i2s_ws_out = ws_reg;
   assign i2s_sd_out = sdo_reg;
   // Open-drain pins only ever pull low; the enable carries the level.
   assign video_err_out = 1'b0;
   assign video_err_oe = err_oe_reg;
   assign lock_out = 1'b0;
   assign lock_oe = lock_oe_reg;
   assign spread_en = spread_reg;
   assign low_rate_band = rate_reg;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   chk_err_hiz_pd: assert property (clk_en && !pd_s |=> !err_oe_reg)
      else $error("error pin driven in power-down");
   chk_lock_hiz_pd: assert property (clk_en && !pd_s |=> !lock_oe_reg)
      else $error("lock pin driven in power-down");
   chk_lock_cfg_low: assert property
      (clk_en && pd_s && ctrl_reg[`CTRL_CFG_LINK] |=> lock_oe_reg)
      else $error("lock released while config link active");
   chk_lock_release: assert property
      (clk_en && pd_s && locked_s && aligned_s && !ctrl_reg[`CTRL_CFG_LINK]
       |=> !lock_oe_reg)
      else $error("lock not released when locked");
   chk_err_thresh: assert property
      (clk_en && pd_s && dec_cnt_reg > CNT_W'(thresh_reg) |=> err_oe_reg)
      else $error("error pin not low over threshold");
   chk_pattern_test_err: assert property
      (clk_en && pd_s && pattern_test && pattern_test_ev ##1 clk_en |=> err_oe_reg)
      else $error("pattern mismatch not flagged");
   chk_pd_clear: assert property (clk_en && !pd_s |=> dec_cnt_reg == '0)
      else $error("count kept through power-down");
   chk_narrow_low: assert property
      (clk_en && upd && !bws_s |=> pixel_data[28:21] == 8'h00)
      else $error("upper bits not low in narrow mode");
   chk_clear_bits: assert property
      (clk_en && upd && bws_s && !ctrl_reg[`CTRL_MCLK_SEL]
       |=> pixel_data[20] == $past(word_s[20])
           && pixel_data[28:27] == $past(word_s[28:27]))
      else $error("bypass bits altered");
   chk_edge_only: assert property (clk_en && !upd |=> $stable(data_reg))
      else $error("data changed off the chosen edge");
   chk_strap_hold: assert property
      (clk_en && !pd_rise |=> $stable(spread_reg) && $stable(rate_reg))
      else $error("strap latch changed without wake");
   chk_oe_follow: assert property
      (clk_en ##1 clk_en |-> pixel_oe == !$past(oen_s))
      else $error("output enable not following pin");

   cov_wake: cover property (pd_rise && spread_s);
   cov_err_low: cover property (!err_oe_reg ##1 err_oe_reg);
   cov_lock_up: cover property (lock_oe_reg ##1 !lock_oe_reg && pd_s);
   cov_write: cover property (wst_reg == BUS_TAKE ##1 s_axi_bvalid);
endmodule : deser_parallel_output_status
`default_nettype wire

// ==== hw/deser_out_defines.svh ====
// Register offsets, field positions and reset values of the output block.
`ifndef DESER_OUT_DEFINES_SVH
`define DESER_OUT_DEFINES_SVH
`define ADDR_CTRL 32'h0000_0000
`define ADDR_THRESH 32'h0000_0004
`define ADDR_STATUS 32'h0000_0008
`define ADDR_ERRCNT 32'h0000_000c
`define CTRL_PATTERN_TEST 0
`define CTRL_ENCRYPT_EN 1
`define CTRL_AUDIO_EN 2
`define CTRL_MCLK_SEL 3
`define CTRL_CFG_LINK 4
`define CTRL_SD_VALUE 5
`define CTRL_W 6
`define CTRL_RST 6'h04
`define THRESH_RST 16'h0010
`define DECRYPT_MASK 29'h07e3ffff
`define NARROW_MASK 29'h001fffff
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== hw/deser_out_pkg.sv ====
// Types shared by the parallel output block.
`default_nettype none
package deser_out_pkg;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_TAKE = 2'b01,
      BUS_RESP = 2'b10
   } bus_state_t;
endpackage : deser_out_pkg
`default_nettype wire

// ==== sim/pixel_sink_model.sv ====
// Display-side sink that captures pixel words and reads the status pins.
`default_nettype none
module pixel_sink_model (
   input wire logic clk_sys,
   input wire logic pixel_clk_out,
   input wire logic [28:0] pixel_data,
   input wire logic edge_sel,
   input wire logic watch,
   input wire logic video_err_out,
   input wire logic video_err_oe,
   input wire logic lock_out,
   input wire logic lock_oe,
   output logic [28:0] cap_word,
   output logic vert_sync,
   output logic horiz_sync,
   output logic err_pin,
   output logic lock_pin,
   output var int bad_edge
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk_q;
   logic [28:0] data_q;
   logic sel_edge;
   // Both status pins are pulled up, so a released pin reads high.
   assign err_pin = video_err_oe ? video_err_out : 1'b1;
   assign lock_pin = lock_oe ? lock_out : 1'b1;
   assign sel_edge = (pclk_q != pixel_clk_out) &&
                     (pixel_clk_out != edge_sel);
   assign vert_sync = cap_word[19];
   assign horiz_sync = cap_word[18];
   initial bad_edge = 0;
   // The word held before the edge is the one a real receiver latches.
   always @(posedge clk_sys) begin
      pclk_q <= pixel_clk_out;
      data_q <= pixel_data;
      if (sel_edge) begin
         cap_word <= data_q;
      end
      if (watch && data_q !== pixel_data && !sel_edge) begin
         bad_edge <= bad_edge + 1;
      end
   end
endmodule : pixel_sink_model
`default_nettype wire

// ==== sim/deser_parallel_output_status_tb_top.sv ====
// Self-checking bench for the parallel output and status block.
`include "deser_out_defines.svh"
`default_nettype none
module deser_parallel_output_status_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [28:0] W1 = 29'h1234_5678;
   localparam logic [28:0] W2 = 29'h0dcb_a987;
   localparam logic [28:0] KEY = 29'h1f1f_3c5a;
   logic clk_sys, resetn, clk_en, link_clk;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [28:0] link_word, key_word, pixel_data, cap_word;
   logic key_sd, decode_err_tgl, pattern_test_err_tgl, plls_locked, word_aligned;
   logic aud_sck, aud_ws, aud_sd, aud_mclk, power_down_n, bus_width_sel;
   logic edge_sel, out_enable_n, spread_strap, rate_range_strap;
   logic pixel_clk_out, pixel_oe, i2s_sck_out, i2s_ws_out, i2s_sd_out;
   logic audio_oe, video_err_out, video_err_oe, lock_out, lock_oe;
   logic spread_en, low_rate_band, watch, vert_sync, horiz_sync;
   logic err_pin, lock_pin;
   int bad_edge, fails, cmp_count;

   deser_parallel_output_status DUT (
      .clk_sys, .resetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_clk, .link_word,
      .key_word, .key_sd, .decode_err_tgl, .pattern_test_err_tgl, .plls_locked,
      .word_aligned, .aud_sck, .aud_ws, .aud_sd, .aud_mclk, .power_down_n,
      .bus_width_sel, .edge_sel, .out_enable_n, .spread_strap,
      .rate_range_strap, .pixel_clk_out, .pixel_data, .pixel_oe,
      .i2s_sck_out, .i2s_ws_out, .i2s_sd_out, .audio_oe, .video_err_out,
      .video_err_oe, .lock_out, .lock_oe, .spread_en, .low_rate_band
   );
   pixel_sink_model sink (
      .clk_sys, .pixel_clk_out, .pixel_data, .edge_sel, .watch,
      .video_err_out, .video_err_oe, .lock_out, .lock_oe, .cap_word,
      .vert_sync, .horiz_sync, .err_pin, .lock_pin, .bad_edge
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Odd offset keeps the link clock out of phase with the system clock.
   initial begin
      link_clk = 1'b0;
      #3;
      forever #40 link_clk = ~link_clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic chk1(input string nm, input logic seen, exp);
      chk(nm, 32'(seen), 32'(exp));
   endtask : chk1

   task automatic wr(input logic [31:0] a, d, input logic [1:0] rs);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do @(posedge clk_sys); while (s_axi_awready !== 1'b1 && ++n < 200);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b1;
      do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1 && ++n < 200);
      s_axi_bready <= 1'b0;
      chk1("write wait", n < 200, 1'b1);
      chk("bresp", 32'(s_axi_bresp), 32'(rs));
   endtask : wr

   task automatic rd(input logic [31:0] a, d, input logic [1:0] rs);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk_sys); while (s_axi_arready !== 1'b1 && ++n < 200);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1 && ++n < 200);
      s_axi_rready <= 1'b0;
      chk1("read wait", n < 200, 1'b1);
      chk("rdata", s_axi_rdata, d);
      chk("rresp", 32'(s_axi_rresp), 32'(rs));
   endtask : rd

   task t_regs;
      rd(`ADDR_CTRL, 32'(`CTRL_RST), `RESP_OKAY);
      rd(`ADDR_THRESH, 32'(`THRESH_RST), `RESP_OKAY);
      rd(32'h10, 32'h0, `RESP_SLVERR);
      wr(32'h10, 32'h0, `RESP_SLVERR);
      $display("register test done");
   endtask : t_regs

   task t_pixel;
      watch <= 1'b1;
      link_word <= W1;
      cyc(40);
      chk("pixel rise", 32'(cap_word), 32'(W1));
      watch <= 1'b0;
      edge_sel <= 1'b1;
      cyc(20);
      watch <= 1'b1;
      link_word <= W2;
      cyc(40);
      chk("pixel fall", 32'(cap_word), 32'(W2));
      chk("edge align", 32'(bad_edge), 32'h0);
      watch <= 1'b0;
      bus_width_sel <= 1'b0;
      cyc(40);
      chk("narrow", 32'(cap_word), 32'(W2 & `NARROW_MASK));
      bus_width_sel <= 1'b1;
      cyc(40);
      chk("wide", 32'(cap_word), 32'(W2));
      $display("pixel test done");
   endtask : t_pixel

   task t_crypt;
      {aud_sck, aud_ws, aud_sd} <= 3'b111;
      key_word <= KEY;
      wr(`ADDR_CTRL, 32'h06, `RESP_OKAY);
      cyc(40);
      chk("decrypt", 32'(cap_word), 32'(W2 ^ (KEY & ~29'h181c_0000)));
      chk1("vert sync", vert_sync, W2[19]);
      chk1("horiz sync", horiz_sync, W2[18]);
      chk1("audio data", i2s_sd_out, 1'b1);
      chk1("audio ws", i2s_ws_out, 1'b1);
      aud_mclk <= 1'b1;
      wr(`ADDR_CTRL, 32'h0e, `RESP_OKAY);
      cyc(40);
      chk1("master clock", cap_word[28], 1'b1);
      key_sd <= 1'b1;
      wr(`ADDR_CTRL, 32'h22, `RESP_OKAY);
      cyc(40);
      chk1("control out", i2s_sd_out, 1'b0);
      chk1("idle sck", i2s_sck_out, 1'b0);
      chk1("idle ws", i2s_ws_out, 1'b0);
      wr(`ADDR_CTRL, 32'h20, `RESP_OKAY);
      cyc(40);
      chk1("control out", i2s_sd_out, 1'b1);
      wr(`ADDR_CTRL, 32'(`CTRL_RST), `RESP_OKAY);
      $display("encryption test done");
   endtask : t_crypt

   task t_status;
      {plls_locked, word_aligned} <= 2'b11;
      cyc(8);
      chk1("lock", lock_pin, 1'b1);
      word_aligned <= 1'b0;
      cyc(8);
      chk1("lock", lock_pin, 1'b0);
      word_aligned <= 1'b1;
      wr(`ADDR_CTRL, 32'h14, `RESP_OKAY);
      cyc(8);
      chk1("lock cfg", lock_pin, 1'b0);
      wr(`ADDR_CTRL, 32'(`CTRL_RST), `RESP_OKAY);
      cyc(8);
      chk1("lock", lock_pin, 1'b1);
      $display("status test done");
   endtask : t_status

   task t_err;
      chk1("spread", spread_en, 1'b1);
      chk1("rate", low_rate_band, 1'b0);
      wr(`ADDR_THRESH, 32'h2, `RESP_OKAY);
      repeat (2) begin
         decode_err_tgl <= ~decode_err_tgl;
         cyc(4);
      end
      cyc(4);
      chk1("at threshold", err_pin, 1'b1);
      decode_err_tgl <= ~decode_err_tgl;
      {spread_strap, rate_range_strap, word_aligned} <= 3'b010;
      cyc(8);
      chk1("over threshold", err_pin, 1'b0);
      chk1("spread held", spread_en, 1'b1);
      chk1("rate held", low_rate_band, 1'b0);
      power_down_n <= 1'b0;
      cyc(8);
      chk1("err released", video_err_oe, 1'b0);
      chk1("lock released", lock_oe, 1'b0);
      power_down_n <= 1'b1;
      word_aligned <= 1'b1;
      cyc(10);
      chk1("spread wake", spread_en, 1'b0);
      chk1("rate wake", low_rate_band, 1'b1);
      chk1("err cleared", err_pin, 1'b1);
      rd(`ADDR_ERRCNT, 32'h0, `RESP_OKAY);
      rd(`ADDR_STATUS, 32'h39, `RESP_OKAY);
      $display("error test done");
   endtask : t_err

   task t_pattern_test;
      wr(`ADDR_CTRL, 32'h05, `RESP_OKAY);
      pattern_test_err_tgl <= ~pattern_test_err_tgl;
      cyc(8);
      chk1("mismatch", err_pin, 1'b0);
      rd(`ADDR_ERRCNT, 32'h0001_0000, `RESP_OKAY);
      wr(`ADDR_ERRCNT, 32'h0, `RESP_OKAY);
      cyc(4);
      chk1("count cleared", err_pin, 1'b1);
      pattern_test_err_tgl <= ~pattern_test_err_tgl;
      cyc(8);
      chk1("mismatch again", err_pin, 1'b0);
      wr(`ADDR_CTRL, 32'(`CTRL_RST), `RESP_OKAY);
      cyc(6);
      chk1("test off", err_pin, 1'b1);
      out_enable_n <= 1'b1;
      cyc(4);
      chk1("pixel oe", pixel_oe, 1'b0);
      chk1("audio oe", audio_oe, 1'b0);
      out_enable_n <= 1'b0;
      cyc(4);
      chk1("pixel oe", pixel_oe, 1'b1);
      $display("pattern and enable test done");
   endtask : t_pattern_test

   task final_report;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   initial begin
      {clk_en, resetn, s_axi_wstrb} = 6'b10_1111;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
      {s_axi_arvalid, s_axi_rready} = 2'b00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      {link_word, key_word} = '0;
      {key_sd, decode_err_tgl, pattern_test_err_tgl, plls_locked, word_aligned} = '0;
      {aud_sck, aud_ws, aud_sd, aud_mclk, edge_sel, out_enable_n} = '0;
      watch = 1'b0;
      // Straps are set before the first wake so their power-up latch shows.
      {power_down_n, bus_width_sel, spread_strap, rate_range_strap} = 4'he;
      fails = 0;
      cmp_count = 0;
      cyc(4);
      resetn <= 1'b1;
      cyc(10);
      t_regs;
      t_pixel;
      t_crypt;
      t_status;
      t_err;
      t_pattern_test;
      final_report;
   end

   // The tests need roughly 5 us; a hang is cut off well beyond that.
   initial begin
      #200us;
      fails++;
      final_report;
   end
endmodule : deser_parallel_output_status_tb_top
`default_nettype wire
